// File: hdl/dmia_core.sv
// Data memory access logic: special-purpose area, general RAM and indirect windows.
// Assumes the CPU datapath issues at most one access per cycle, synchronous to clk.
`timescale 1ns/10ps
module dmia_core #(
    parameter int           NUM_SEC  = dmia_pkg::NUM_SECTORS,
    parameter logic [127:0] RO_MASK  = dmia_pkg::PROTECT_MASK,
    parameter logic [127:0] UNU_MASK = dmia_pkg::UNUSED_MASK
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // CPU access request
    input  wire logic [$clog2(NUM_SEC)-1:0]    cpuSector,
    input  wire logic [dmia_pkg::ADDR_W-1:0]   cpuAddr,
    input  wire logic                          cpuRdEn,
    input  wire logic                          cpuWrEn,
    input  wire logic [dmia_pkg::DATA_W-1:0]   cpuWrData,
    input  wire logic                          cpuBitEn,
    input  wire logic                          cpuBitVal,
    input  wire logic [2:0]                    cpuBitSel,
    // CPU read answer
    output logic      [dmia_pkg::DATA_W-1:0]   cpuRdData,
    output logic                               cpuRdValid,
    // Hardware update of special registers
    input  wire logic                          hwWrEn,
    input  wire logic [6:0]                    hwWrAddr,
    input  wire logic [dmia_pkg::DATA_W-1:0]   hwWrData
);
    import dmia_pkg::*;

    localparam int SEC_W = $clog2(NUM_SEC);
    localparam int IDX_W = SEC_W + 7;

    // Address decode helpers
    function automatic logic isUnused(input logic [6:0] a);
        return UNU_MASK[a];
    endfunction : isUnused

    function automatic logic isProtected(input logic [6:0] a);
        return RO_MASK[a];
    endfunction : isProtected

    function automatic logic isWindow(input logic [7:0] a);
        return (a == WIN_ZERO_ADDR) || (a == WIN_ONE_ADDR) || (a == WIN_TWO_ADDR);
    endfunction : isWindow

    // Special register storage and read answer
    logic [SFR_DEPTH-1:0][DATA_W-1:0] sfrQ;
    logic [SFR_DEPTH-1:0][DATA_W-1:0] sfrD;
    logic [DATA_W-1:0]                rdDataQ;
    logic [DATA_W-1:0]                rdDataD;
    logic                             rdValidQ;
    logic                             rdValidD;

    // Resolution of the access
    logic [7:0]        tgtSec;
    logic [7:0]        tgtAddr;
    logic              secOk;
    logic              tgtIsWin;
    dmia_class_t       tgtClass;
    logic [IDX_W-1:0]  ramIdx;
    logic [DATA_W-1:0] ramRd;
    logic              ramWe;
    logic [DATA_W-1:0] curByte;
    logic [DATA_W-1:0] newByte;
    logic [DATA_W-1:0] readVal;
    logic              doWr;
    logic              sfrWr;
    logic [6:0]        sfrIdx;
    logic [DATA_W-1:0] ptrZero;
    logic [DATA_W-1:0] ptrOneLo;
    logic [DATA_W-1:0] ptrOneSe;
    logic [DATA_W-1:0] ptrTwoLo;
    logic [DATA_W-1:0] ptrTwoSe;
    logic [DATA_W-1:0] bitMask;

    // Pointers live in ordinary special register storage
    assign ptrZero  = sfrQ[PTR_ZERO_ADDR[6:0]];
    assign ptrOneLo = sfrQ[PTR_ONE_LO_ADDR[6:0]];
    assign ptrOneSe = sfrQ[PTR_ONE_SE_ADDR[6:0]];
    assign ptrTwoLo = sfrQ[PTR_TWO_LO_ADDR[6:0]];
    assign ptrTwoSe = sfrQ[PTR_TWO_SE_ADDR[6:0]];

    // Windows redirect to their pointer target
    always_comb begin
        tgtSec  = {{(8-SEC_W){1'b0}}, cpuSector};
        tgtAddr = cpuAddr;
        if (cpuSector == '0 && cpuAddr == WIN_ZERO_ADDR) begin
            tgtSec  = 8'h00;
            tgtAddr = ptrZero;
        end else if (cpuSector == '0 && cpuAddr == WIN_ONE_ADDR) begin
            tgtSec  = ptrOneSe;
            tgtAddr = ptrOneLo;
        end else if (cpuSector == '0 && cpuAddr == WIN_TWO_ADDR) begin
            tgtSec  = ptrTwoSe;
            tgtAddr = ptrTwoLo;
        end
    end

    // Classify the resolved location
    always_comb begin
        secOk    = tgtSec < 8'(NUM_SEC);
        tgtIsWin = (tgtSec == 8'h00) && isWindow(tgtAddr);
        if (!secOk) begin
            tgtClass = DMIA_NONE;
        end else if (tgtAddr[GP_SEL_BIT]) begin
            tgtClass = DMIA_GP;
        end else if (tgtSec == 8'h00 && !tgtIsWin && !isUnused(tgtAddr[6:0])) begin
            tgtClass = DMIA_SFR;
        end else begin
            tgtClass = DMIA_NONE;
        end
    end

    assign ramIdx  = {tgtSec[SEC_W-1:0], tgtAddr[6:0]};
    assign sfrIdx  = tgtAddr[6:0];
    assign bitMask = 8'h01 << cpuBitSel;
    assign doWr    = cpuWrEn || cpuBitEn;

    // Byte or single-bit write value
    always_comb begin
        curByte = ZERO_BYTE;
        if (tgtClass == DMIA_GP) begin
            curByte = ramRd;
        end else if (tgtClass == DMIA_SFR) begin
            curByte = sfrQ[sfrIdx];
        end
        if (cpuBitEn) begin
            newByte = cpuBitVal ? (curByte | bitMask) : (curByte & ~bitMask);
        end else begin
            newByte = cpuWrData;
        end
    end

    // Write strobes
    assign ramWe = doWr && (tgtClass == DMIA_GP);
    assign sfrWr = doWr && (tgtClass == DMIA_SFR) && !isProtected(sfrIdx);

    // General RAM of all sectors
    dmia_ram #(
        .DEPTH (NUM_SEC * 128),
        .IDX_W (IDX_W)
    ) u_ram (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (ramWe),
        .idx   (ramIdx),
        .wdata (newByte),
        .rdata (ramRd)
    );

    // Special register next state, hardware update wins
    always_comb begin
        sfrD = sfrQ;
        if (sfrWr) begin
            sfrD[sfrIdx] = newByte;
        end
        if (hwWrEn) begin
            sfrD[hwWrAddr] = hwWrData;
        end
    end

    // Read answer, value before any same-cycle write
    always_comb begin
        unique case (tgtClass)
            DMIA_GP:   readVal = ramRd;
            DMIA_SFR:  readVal = sfrQ[sfrIdx];
            DMIA_NONE: readVal = ZERO_BYTE;
        endcase
        rdDataD  = cpuRdEn ? readVal : rdDataQ;
        rdValidD = cpuRdEn;
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < SFR_DEPTH; i++) begin
                sfrQ[i] <= RESET_BYTE;
            end
            rdDataQ  <= ZERO_BYTE;
            rdValidQ <= 1'b0;
        end else begin
            sfrQ     <= sfrD;
            rdDataQ  <= rdDataD;
            rdValidQ <= rdValidD;
        end
    end

    assign cpuRdData  = rdDataQ;
    assign cpuRdValid = rdValidQ;

    // Checks on the data path
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Read answer one cycle after request
    rdAnswer_a: assert property (cpuRdEn |=> cpuRdValid)
        else $error("read answer missing");

    // Unused direct address reads zero
    unusedZero_a: assert property (cpuRdEn && cpuSector == '0 && !cpuAddr[7] && UNU_MASK[cpuAddr[6:0]]
        |=> cpuRdData == 8'h00)
        else $error("unused address read not zero");

    // Window pointing at a window reads zero
    windowSelf_a: assert property (cpuRdEn && tgtIsWin && secOk |=> cpuRdData == 8'h00)
        else $error("window self read not zero");

    // Window pointing at a window writes nothing
    windowNoStore_a: assert property (doWr && tgtIsWin && !hwWrEn |-> !ramWe ##1 $stable(sfrQ))
        else $error("window self write stored");

    // Protected register keeps its value
    roProtect_a: assert property (doWr && tgtClass == DMIA_SFR && RO_MASK[sfrIdx] && !hwWrEn
        |=> sfrQ == $past(sfrQ))
        else $error("protected register written");

    // Window zero reaches sector 0 RAM at pointer
    winZeroRoute_a: assert property (cpuWrEn && cpuSector == '0 && cpuAddr == WIN_ZERO_ADDR && ptrZero[7]
        |-> ramWe && ramIdx == {{SEC_W{1'b0}}, ptrZero[6:0]})
        else $error("window zero routed wrongly");

    // Window one uses sector pointer and low pointer
    winOneRoute_a: assert property (cpuWrEn && cpuSector == '0 && cpuAddr == WIN_ONE_ADDR && ptrOneLo[7]
        && ptrOneSe < 8'(NUM_SEC) |-> ramWe && ramIdx == {ptrOneSe[SEC_W-1:0], ptrOneLo[6:0]})
        else $error("window one routed wrongly");

    // Window two uses sector pointer and low pointer
    winTwoRoute_a: assert property (cpuWrEn && cpuSector == '0 && cpuAddr == WIN_TWO_ADDR && ptrTwoLo[7]
        && ptrTwoSe < 8'(NUM_SEC) |-> ramWe && ramIdx == {ptrTwoSe[SEC_W-1:0], ptrTwoLo[6:0]})
        else $error("window two routed wrongly");

    // Bit operation touches only the selected bit
    bitKeep_a: assert property (cpuBitEn && tgtClass != DMIA_NONE
        |-> ((newByte ^ curByte) & ~bitMask) == 8'h00 && newByte[cpuBitSel] == cpuBitVal)
        else $error("bit operation disturbed other bits");

    // Pointer write reads back on the next direct read
    ptrReadBack_a: assert property (cpuWrEn && !cpuBitEn && cpuSector == '0 && cpuAddr == PTR_ZERO_ADDR
        && !hwWrEn && !RO_MASK[1] ##1 cpuRdEn && cpuSector == '0 && cpuAddr == PTR_ZERO_ADDR
        |=> cpuRdData == $past(cpuWrData, 2))
        else $error("pointer read back wrong");

    // Upper half of a sector goes to RAM
    gpDecode_a: assert property (doWr && secOk && tgtAddr[7] |-> ramWe && !sfrWr)
        else $error("upper half not decoded to RAM");

    // Valid only follows a read
    rdPulse_a: assert property (!cpuRdEn |=> !cpuRdValid)
        else $error("read valid without a read");

    // Read data stands until the next read
    rdHold_a: assert property (!cpuRdEn |=> $stable(cpuRdData))
        else $error("read data moved without a read");

    // A RAM write is seen by the next access to the same byte
    ramLand_a: assert property (ramWe ##1 ramIdx == $past(ramIdx) |-> ramRd == $past(newByte))
        else $error("RAM write not stored");

    // Hardware update lands even on protected registers
    hwWins_a: assert property (hwWrEn |=> sfrQ[$past(hwWrAddr)] == $past(hwWrData))
        else $error("hardware update lost");

    // Byte write to a writable special register is stored
    sfrLand_a: assert property (sfrWr && !cpuBitEn && !(hwWrEn && hwWrAddr == sfrIdx)
        |=> sfrQ[$past(sfrIdx)] == $past(cpuWrData))
        else $error("special register write lost");

    // Upper sectors have no special registers
    upperSfr_a: assert property (doWr && cpuSector != '0 && !cpuAddr[GP_SEL_BIT] |-> !ramWe && !sfrWr)
        else $error("special area of an upper sector written");

    // Window with a missing sector reads zero
    badSector_a: assert property (cpuRdEn && !secOk |=> cpuRdData == 8'h00)
        else $error("missing sector read not zero");

    // Window with a missing sector stores nothing
    badSectorWr_a: assert property (doWr && !secOk |-> !ramWe && !sfrWr)
        else $error("missing sector write stored");

    // Unused direct address never stores
    unusedNoStore_a: assert property (doWr && cpuSector == '0 && !cpuAddr[GP_SEL_BIT] && UNU_MASK[cpuAddr[6:0]]
        |-> !ramWe && !sfrWr)
        else $error("unused address stored");

    // Main scenarios
    cWinOneSec_c: cover property (ramWe && cpuAddr == WIN_ONE_ADDR && ptrOneSe == 8'h01);
    cBitSet_c:    cover property (cpuBitEn && cpuBitVal && tgtClass == DMIA_GP);
    cUnusedRd_c:  cover property (cpuRdEn && tgtClass == DMIA_NONE && !tgtIsWin);
    cWinTwoRd_c:  cover property (cpuRdEn && cpuAddr == WIN_TWO_ADDR && tgtClass == DMIA_GP);
    cBadSec_c:    cover property (cpuRdEn && !secOk);

endmodule : dmia_core

// File: hdl/dmia_pkg.sv
// Shared constants for the data memory and indirect addressing block.
// Assumes one CPU datapath master on a single clock and reset.
package dmia_pkg;

    // Data and address widths
    localparam int          DATA_W      = 8;
    localparam int          ADDR_W      = 8;
    localparam int          SFR_DEPTH   = 128;
    localparam int          NUM_SECTORS = 4;

    // Indirect windows and their pointers
    localparam logic [7:0]  WIN_ZERO_ADDR   = 8'h00;
    localparam logic [7:0]  PTR_ZERO_ADDR   = 8'h01;
    localparam logic [7:0]  WIN_ONE_ADDR    = 8'h02;
    localparam logic [7:0]  PTR_ONE_LO_ADDR = 8'h03;
    localparam logic [7:0]  PTR_ONE_SE_ADDR = 8'h04;
    localparam logic [7:0]  WIN_TWO_ADDR    = 8'h0c;
    localparam logic [7:0]  PTR_TWO_LO_ADDR = 8'h0d;
    localparam logic [7:0]  PTR_TWO_SE_ADDR = 8'h0e;

    // Area split within a sector
    localparam logic [7:0]  GP_BASE_ADDR = 8'h80;
    localparam int          GP_SEL_BIT   = 7;

    // Values
    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [7:0]  ZERO_BYTE  = 8'h00;

    // Unused special-purpose locations in sector 0 (one bit per address)
    localparam logic [127:0] UNUSED_MASK = 128'hffc0001c_00000000_00000000_00000000;
    // Write-protected locations, none by default
    localparam logic [127:0] PROTECT_MASK = 128'h0;

    // Address class of a resolved access
    typedef enum logic [1:0] {
        DMIA_GP,
        DMIA_SFR,
        DMIA_NONE
    } dmia_class_t;

endpackage : dmia_pkg

// File: hdl/dmia_ram.sv
// General-purpose RAM of all sectors, held in flip-flops.
// Assumes a single write port and an asynchronous read at the same index.
`timescale 1ns/10ps
module dmia_ram #(
    parameter int DEPTH = 512,
    parameter int IDX_W = 9
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // Access port
    input  wire logic                          we,
    input  wire logic [IDX_W-1:0]              idx,
    input  wire logic [dmia_pkg::DATA_W-1:0]   wdata,
    output logic      [dmia_pkg::DATA_W-1:0]   rdata
);
    import dmia_pkg::*;

    logic [DEPTH-1:0][DATA_W-1:0] memQ;
    logic [DEPTH-1:0][DATA_W-1:0] memD;

    // Read returns the last value written
    assign rdata = memQ[idx];

    // Next contents
    always_comb begin
        memD = memQ;
        if (we) begin
            memD[idx] = wdata;
        end
    end

    // Storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                memQ[i] <= RESET_BYTE;
            end
        end else begin
            memQ <= memD;
        end
    end

endmodule : dmia_ram

// File: bench/dmia_cpu_model.sv
// CPU datapath model issuing one data memory access per request.
// Assumes the block takes strobes at rising clk, read answer one cycle later.
`timescale 1ns/10ps
module dmia_cpu_model (
    // Clock
    input  wire logic       clk,
    // Request
    output logic [1:0]      cpuSector,
    output logic [7:0]      cpuAddr,
    output logic            cpuRdEn,
    output logic            cpuWrEn,
    output logic [7:0]      cpuWrData,
    output logic            cpuBitEn,
    output logic            cpuBitVal,
    output logic [2:0]      cpuBitSel,
    // Answer
    input  wire logic [7:0] cpuRdData,
    input  wire logic       cpuRdValid
);
    // Quiet request lines at time zero
    initial begin
        cpuSector = 2'h0;
        cpuAddr   = 8'h00;
        cpuRdEn   = 1'b0;
        cpuWrEn   = 1'b0;
        cpuWrData = 8'h00;
        cpuBitEn  = 1'b0;
        cpuBitVal = 1'b0;
        cpuBitSel = 3'h0;
    end

    // Drive a request at the falling edge, hold it over the taking edge
    task automatic req(input logic [1:0] s, input logic [7:0] a, input logic [2:0] k, input logic [7:0] d);
        @(negedge clk);
        cpuSector = s;
        cpuAddr   = a;
        cpuRdEn   = k[2];
        cpuWrEn   = k[1];
        cpuBitEn  = k[0];
        cpuWrData = k[1] ? d : ~cpuWrData; // Unused data keeps moving
        cpuBitSel = d[2:0];
        cpuBitVal = d[3];
        @(posedge clk);
    endtask : req

    // Read and collect the answer at the falling edge after it was taken
    task automatic rd(input logic [1:0] s, input logic [7:0] a, output logic [7:0] q, output logic v);
        req(s, a, 3'h4, 8'h00);
        @(negedge clk);
        q       = cpuRdData;
        v       = cpuRdValid;
        cpuRdEn = 1'b0;
    endtask : rd

    // Drop all strobes at the falling edge so no request repeats
    task automatic idle();
        @(negedge clk);
        cpuRdEn  = 1'b0;
        cpuWrEn  = 1'b0;
        cpuBitEn = 1'b0;
    endtask : idle
endmodule : dmia_cpu_model

// File: bench/data_memory_indirect_addressing_tb.sv
// Self-checking bench for the data memory and indirect window block.
// Assumes the CPU model file; one protected register placed at 20H.
`timescale 1ns/10ps
module data_memory_indirect_addressing_tb;
    logic       clk;
    logic       rst_n;
    logic [1:0] cpuSector;
    logic [7:0] cpuAddr;
    logic       cpuRdEn;
    logic       cpuWrEn;
    logic [7:0] cpuWrData;
    logic       cpuBitEn;
    logic       cpuBitVal;
    logic [2:0] cpuBitSel;
    logic [7:0] cpuRdData;
    logic       cpuRdValid;
    logic       hwWrEn;
    logic [6:0] hwWrAddr;
    logic [7:0] hwWrData;
    logic [7:0] q;
    logic       v;
    logic [7:0] unused [4] = '{8'h62, 8'h64, 8'h76, 8'h7f};
    int         nFail;
    int         totalChecks;

    // Free-running clock
    always #2 clk = ~clk;

    dmia_core #(.RO_MASK(128'h100000000)) dut_u (
        .clk(clk), .rst_n(rst_n), .cpuSector(cpuSector), .cpuAddr(cpuAddr),
        .cpuRdEn(cpuRdEn), .cpuWrEn(cpuWrEn), .cpuWrData(cpuWrData),
        .cpuBitEn(cpuBitEn), .cpuBitVal(cpuBitVal), .cpuBitSel(cpuBitSel),
        .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid),
        .hwWrEn(hwWrEn), .hwWrAddr(hwWrAddr), .hwWrData(hwWrData)
    );

    dmia_cpu_model cpu_u (
        .clk(clk), .cpuSector(cpuSector), .cpuAddr(cpuAddr),
        .cpuRdEn(cpuRdEn), .cpuWrEn(cpuWrEn), .cpuWrData(cpuWrData),
        .cpuBitEn(cpuBitEn), .cpuBitVal(cpuBitVal), .cpuBitSel(cpuBitSel),
        .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid)
    );

    // Verdict and end of run
    task automatic end_sim;
        $display("checks %0d, failures %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // Byte write and bit set or clear
    task automatic wr(input logic [1:0] s, input logic [7:0] a, input logic [7:0] d);
        cpu_u.req(s, a, 3'h2, d);
    endtask : wr
    task automatic bop(input logic [1:0] s, input logic [7:0] a, input logic [2:0] b, input logic val);
        cpu_u.req(s, a, 3'h1, {4'h0, val, b});
    endtask : bop

    // Read and compare data plus the valid pulse
    task automatic rdc(input logic [1:0] s, input logic [7:0] a, input logic [7:0] e);
        cpu_u.rd(s, a, q, v);
        totalChecks += 1;
        if (v !== 1'b1 || q !== e) begin
            nFail += 1;
            $display("CHECK FAILED at %0t: read %h:%h got %h valid %b, want %h", $time, s, a, q, v, e);
        end
    endtask : rdc

    // Watchdog against a hung sequence
    initial begin
        #20000;
        nFail += 1;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_sim();
    end

    // Main sequence
    initial begin
        clk         = 1'b0;
        rst_n       = 1'b0;
        hwWrEn      = 1'b0;
        hwWrAddr    = 7'h00;
        hwWrData    = 8'h00;
        nFail       = 0;
        totalChecks = 0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        rdc(2'h0, 8'h80, 8'h00);
        rdc(2'h0, 8'h01, 8'h00);
        // Both ends of RAM in every sector
        for (int s = 0; s < 4; s++) begin
            wr(s[1:0], 8'h80, 8'h10 + 8'(s));
            wr(s[1:0], 8'hff, 8'he0 + 8'(s));
        end
        for (int s = 0; s < 4; s++) begin
            rdc(s[1:0], 8'h80, 8'h10 + 8'(s));
            rdc(s[1:0], 8'hff, 8'he0 + 8'(s));
        end
        // Back-to-back bit set then clear
        wr(2'h0, 8'h90, 8'ha5);
        bop(2'h0, 8'h90, 3'h1, 1'b1);
        bop(2'h0, 8'h90, 3'h7, 1'b0);
        rdc(2'h0, 8'h90, 8'h27);
        // Unused places drop writes
        foreach (unused[i]) begin
            wr(2'h0, unused[i], 8'hff);
            rdc(2'h0, unused[i], 8'h00);
        end
        wr(2'h1, 8'h10, 8'hff);
        rdc(2'h1, 8'h10, 8'h00);
        // Protected register takes only the hardware update
        @(negedge clk);
        hwWrEn   = 1'b1;
        hwWrAddr = 7'h20;
        hwWrData = 8'h3c;
        @(negedge clk);
        hwWrEn = 1'b0;
        wr(2'h0, 8'h20, 8'hff);
        rdc(2'h0, 8'h20, 8'h3c);
        wr(2'h0, 8'h21, 8'h5a);
        rdc(2'h0, 8'h21, 8'h5a);
        // Window zero, pointer stepped
        wr(2'h0, 8'h01, 8'h90);
        wr(2'h0, 8'h00, 8'haa);
        rdc(2'h0, 8'h90, 8'haa);
        wr(2'h0, 8'h01, 8'h91);
        wr(2'h0, 8'h00, 8'hbb);
        wr(2'h1, 8'h91, 8'h11);
        rdc(2'h0, 8'h91, 8'hbb);
        rdc(2'h0, 8'h01, 8'h91);
        rdc(2'h0, 8'h00, 8'hbb);
        // Window one into sector 1
        wr(2'h0, 8'h04, 8'h01);
        wr(2'h0, 8'h03, 8'h80);
        wr(2'h0, 8'h02, 8'hcc);
        rdc(2'h1, 8'h80, 8'hcc);
        rdc(2'h0, 8'h80, 8'h10);
        rdc(2'h0, 8'h02, 8'hcc);
        // Window two into sector 3
        wr(2'h0, 8'h0e, 8'h03);
        wr(2'h0, 8'h0d, 8'hff);
        wr(2'h0, 8'h0c, 8'hdd);
        rdc(2'h3, 8'hff, 8'hdd);
        rdc(2'h2, 8'hff, 8'he2);
        // Window zero aimed at window two
        wr(2'h0, 8'h01, 8'h0c);
        rdc(2'h0, 8'h00, 8'h00);
        wr(2'h0, 8'h00, 8'hee);
        rdc(2'h3, 8'hff, 8'hdd);
        rdc(2'h0, 8'h0d, 8'hff);
        // Window one aimed past the last sector
        wr(2'h0, 8'h04, 8'h04);
        wr(2'h0, 8'h02, 8'h77);
        rdc(2'h0, 8'h02, 8'h00);
        rdc(2'h0, 8'h80, 8'h10);
        // Pointer read straight after its write
        wr(2'h0, 8'h01, 8'h33);
        rdc(2'h0, 8'h01, 8'h33);
        // Window zero into a special register, bit operations there
        wr(2'h0, 8'h01, 8'h21);
        bop(2'h0, 8'h21, 3'h0, 1'b1);
        bop(2'h0, 8'h00, 3'h7, 1'b1);
        rdc(2'h0, 8'h00, 8'hdb);
        bop(2'h0, 8'h20, 3'h7, 1'b1);
        rdc(2'h0, 8'h20, 8'h3c);
        // Hardware update wins over a CPU write in the same cycle
        fork
            begin
                wr(2'h0, 8'h21, 8'h77);
                rdc(2'h0, 8'h21, 8'h66);
            end
            begin
                @(negedge clk);
                hwWrEn   = 1'b1;
                hwWrAddr = 7'h21;
                hwWrData = 8'h66;
                @(negedge clk);
                hwWrEn = 1'b0;
            end
        join
        // Read data stands over a later write
        wr(2'h2, 8'h81, 8'h55);
        cpu_u.idle();
        totalChecks += 1;
        if (cpuRdData !== 8'h66) begin
            nFail += 1;
            $display("CHECK FAILED at %0t: read data did not hold, got %h", $time, cpuRdData);
        end
        rdc(2'h2, 8'h81, 8'h55);
        // Mid-run reset clears all storage
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rdc(2'h3, 8'hff, 8'h00);
        rdc(2'h0, 8'h21, 8'h00);
        end_sim();
    end
endmodule : data_memory_indirect_addressing_tb
